// File: hdl/baud_rate_divider.sv
// What this block does
// - One rate timer, 8 or 16 bits wide, serves both serial modes.
// - After reset the timer is 8 bits wide; the wide select makes it 16.
// - The timer runs freely with its period set by the divisor bytes.
// - In asynchronous mode the multiplier follows high rate and width.
// - In clocked mode the high rate select is ignored.
// - A write to either divisor byte clears the timer at once.
// - Asynchronous, 8 bit, low rate: clock over 64 times divisor plus one.
// - Asynchronous, 16 bit, low rate: clock over 16 times divisor plus one.
// - Clocked mode, any width: clock over 4 times divisor plus one.
// - At 16 bits the divisor is the high byte above the low byte; at 8 bits it is the low byte alone.
//
// Register access over Avalon-MM and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none

module baud_rate_divider
	import rate_pkg::*;
(
	input  wire logic        clk_sys_i,
	input  wire logic        reset_i,
	input  wire logic [4:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	input  wire logic        receiver_idle_i,
	input  wire logic        transmit_empty_i,
	output logic             rate_tick_o,
	output rate_cfg_t        rate_cfg_o
);

	// ==========================================================
	// Bus slave handshake
	typedef enum logic [0:0] {
		BUS_IDLE   = 1'b0,
		BUS_ANSWER = 1'b1
	} bus_state_t;

	bus_state_t  bus_state_q;
	logic        ack;
	logic        req;
	logic        wr_take;
	logic [31:0] rdata_q;

	// Every access waits one cycle so read data can come from a flip-flop
	// loaded at the edge that first sees the request
	assign req               = avs_read_i | avs_write_i;
	assign ack               = (bus_state_q == BUS_ANSWER);
	assign avs_waitrequest_o = req & ~ack;
	assign wr_take           = avs_write_i & ack;
	assign avs_readdata_o    = rdata_q;

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			bus_state_q <= BUS_IDLE;
		end else begin
			unique case (bus_state_q)
				BUS_IDLE: begin
					if (req) begin
						bus_state_q <= BUS_ANSWER;
					end
				end
				BUS_ANSWER: begin
					bus_state_q <= BUS_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Address decode
	logic sel_rate;
	logic sel_tx;
	logic sel_rx;
	logic sel_low;
	logic sel_high;

	assign sel_rate = (avs_address_i == OFS_RATE_CONTROL);
	assign sel_tx   = (avs_address_i == OFS_TRANSMIT_CONTROL);
	assign sel_rx   = (avs_address_i == OFS_RECEIVE_CONTROL);
	assign sel_low  = (avs_address_i == OFS_DIVISOR_LOW_BYTE);
	assign sel_high = (avs_address_i == OFS_DIVISOR_HIGH_BYTE);

	// ==========================================================
	// Software registers
	logic [7:0] rate_control_q;
	logic [7:0] transmit_control_q;
	logic [7:0] receive_control_q;
	logic [7:0] divisor_low_byte_q;
	logic [7:0] divisor_high_byte_q;
	logic [7:0] wbyte;

	assign wbyte = avs_writedata_i[7:0];

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			rate_control_q <= REG_RESET;
		end else if (wr_take && sel_rate) begin
			rate_control_q <= wbyte & RATE_CONTROL_WMASK;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			transmit_control_q <= REG_RESET;
		end else if (wr_take && sel_tx) begin
			transmit_control_q <= wbyte & TRANSMIT_CONTROL_WMASK;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			receive_control_q <= REG_RESET;
		end else if (wr_take && sel_rx) begin
			receive_control_q <= wbyte & RECEIVE_CONTROL_WMASK;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			divisor_low_byte_q <= REG_RESET;
		end else if (wr_take && sel_low) begin
			divisor_low_byte_q <= wbyte;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			divisor_high_byte_q <= REG_RESET;
		end else if (wr_take && sel_high) begin
			divisor_high_byte_q <= wbyte;
		end
	end

	// ==========================================================
	// Read data path
	// Status bits come straight from the serial logic, not from storage
	logic [7:0] rbyte;

	always_comb begin
		rbyte = 8'h00;
		if (sel_rate) begin
			rbyte = rate_control_q;
			rbyte[RC_IDLE_BIT] = receiver_idle_i;
		end else if (sel_tx) begin
			rbyte = transmit_control_q;
			if (transmit_empty_i) begin
				rbyte = rbyte | TC_EMPTY_READ;
			end
		end else if (sel_rx) begin
			rbyte = receive_control_q;
		end else if (sel_low) begin
			rbyte = divisor_low_byte_q;
		end else if (sel_high) begin
			rbyte = divisor_high_byte_q;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			rdata_q <= 32'h0000_0000;
		end else if (avs_read_i && !ack) begin
			rdata_q <= {24'h00_0000, rbyte};
		end
	end

	// ==========================================================
	// Mode selection
	logic clocked_mode;
	logic wide_divider_select;
	logic high_rate_select;
	logic clock_polarity;

	assign clocked_mode        = transmit_control_q[TC_CLOCKED_BIT];
	assign high_rate_select    = transmit_control_q[TC_HIGH_BIT];
	assign wide_divider_select = rate_control_q[RC_WIDE_BIT];
	assign clock_polarity      = rate_control_q[RC_POLARITY_BIT];

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			rate_cfg_o <= '0;
		end else begin
			rate_cfg_o.clocked_mode        <= clocked_mode;
			rate_cfg_o.wide_divider_select <= wide_divider_select;
			rate_cfg_o.high_rate_select    <= high_rate_select;
			rate_cfg_o.clock_polarity      <= clock_polarity;
		end
	end

	// ==========================================================
	// Multiplier: last prescale count
	logic [PRE_W-1:0] pre_last;

	always_comb begin
		pre_last = PRE_LAST_X64;
		if (clocked_mode) begin
			pre_last = PRE_LAST_X4;
		end else begin
			unique case ({wide_divider_select, high_rate_select})
				2'b00: pre_last = PRE_LAST_X64;
				2'b01: pre_last = PRE_LAST_X16;
				2'b10: pre_last = PRE_LAST_X16;
				2'b11: pre_last = PRE_LAST_X4;
			endcase
		end
	end

	// ==========================================================
	// Divisor value
	// Narrow mode drops the high byte so a stale value cannot stretch it
	logic [15:0] divisor;

	always_comb begin
		if (wide_divider_select) begin
			divisor = {divisor_high_byte_q, divisor_low_byte_q};
		end else begin
			divisor = {8'h00, divisor_low_byte_q};
		end
	end

	// ==========================================================
	// Free running rate timer
	logic [PRE_W-1:0] pre_q;
	logic [15:0]      timer_q;
	logic             div_write;
	logic             pre_wrap;
	logic             timer_wrap;

	// Compares use >= so a mode change mid count wraps at once
	// instead of running on to overflow
	assign div_write  = wr_take & (sel_low | sel_high);
	assign pre_wrap   = (pre_q >= pre_last);
	assign timer_wrap = pre_wrap & (timer_q >= divisor);

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			pre_q <= PRE_RESET;
		end else if (div_write || pre_wrap) begin
			pre_q <= PRE_RESET;
		end else begin
			pre_q <= pre_q + 6'd1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			timer_q <= TIMER_RESET;
		end else if (div_write || timer_wrap) begin
			timer_q <= TIMER_RESET;
		end else if (pre_wrap) begin
			timer_q <= timer_q + 16'd1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			rate_tick_o <= 1'b0;
		end else begin
			// A divisor write drops the tick of the period it cuts short
			rate_tick_o <= timer_wrap & ~div_write;
		end
	end

endmodule : baud_rate_divider

`default_nettype wire

// File: hdl/rate_pkg.sv
package rate_pkg;

	// ==========================================================
	// Register map (byte addresses, one aligned word each)
	localparam logic [4:0] OFS_RATE_CONTROL      = 5'h00;
	localparam logic [4:0] OFS_TRANSMIT_CONTROL  = 5'h04;
	localparam logic [4:0] OFS_RECEIVE_CONTROL   = 5'h08;
	localparam logic [4:0] OFS_DIVISOR_LOW_BYTE  = 5'h0C;
	localparam logic [4:0] OFS_DIVISOR_HIGH_BYTE = 5'h10;

	// ==========================================================
	// Field positions
	localparam int RC_IDLE_BIT     = 6;
	localparam int RC_POLARITY_BIT = 4;
	localparam int RC_WIDE_BIT     = 3;
	localparam int TC_CLOCKED_BIT  = 4;
	localparam int TC_HIGH_BIT     = 2;

	// ==========================================================
	// Writable masks and reset values
	localparam logic [7:0] RATE_CONTROL_WMASK     = 8'h18;
	localparam logic [7:0] TRANSMIT_CONTROL_WMASK = 8'hFD;
	localparam logic [7:0] RECEIVE_CONTROL_WMASK  = 8'hF8;
	localparam logic [7:0] REG_RESET              = 8'h00;
	localparam logic [7:0] TC_EMPTY_READ          = 8'h02;

	// ==========================================================
	// Prescale multipliers
	localparam int         PRE_W          = 6;
	localparam logic [5:0] PRE_LAST_X64   = 6'h3F;
	localparam logic [5:0] PRE_LAST_X16   = 6'h0F;
	localparam logic [5:0] PRE_LAST_X4    = 6'h03;
	localparam logic [5:0] PRE_RESET      = 6'h00;
	localparam logic [15:0] TIMER_RESET   = 16'h0000;

	// ==========================================================
	// Configuration carried to the serial logic
	typedef struct packed {
		logic clocked_mode;
		logic wide_divider_select;
		logic high_rate_select;
		logic clock_polarity;
	} rate_cfg_t;

endpackage : rate_pkg

// File: dv/baud_rate_divider_properties.sv
`timescale 1ns/10ps
`default_nettype none
module baud_rate_divider_properties
	import rate_pkg::*;
(
	input wire logic        clk_sys_i,
	input wire logic        reset_i,
	input wire logic [4:0]  avs_address_i,
	input wire logic        avs_read_i,
	input wire logic        avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic        avs_waitrequest_o,
	input wire logic        receiver_idle_i,
	input wire logic        transmit_empty_i,
	input wire logic        rate_tick_o,
	input wire rate_cfg_t   rate_cfg_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	// ==========================================================
	// Accepted writes
	sequence wr_done(logic [4:0] a);
		avs_write_i && !avs_waitrequest_o && avs_address_i == a;
	endsequence
	sequence div_done;
		wr_done(OFS_DIVISOR_LOW_BYTE) or wr_done(OFS_DIVISOR_HIGH_BYTE);
	endsequence
	// ==========================================================
	// Checks
	wait_high_a: assert property ($rose(avs_read_i | avs_write_i)
		|-> avs_waitrequest_o) else $error("new request not held");
	wait_low_a: assert property ((avs_read_i | avs_write_i) && avs_waitrequest_o
		|=> !avs_waitrequest_o) else $error("request not answered");
	idle_ready_a: assert property (!(avs_read_i | avs_write_i)
		|-> !avs_waitrequest_o) else $error("wait without request");
	read_zero_a: assert property (avs_read_i && !avs_waitrequest_o
		|-> avs_readdata_o[31:8] == 24'h00_0000) else $error("upper read bits");
	tick_gap_a: assert property (rate_tick_o |=> !rate_tick_o [*3])
		else $error("tick period too short");
	timer_clear_a: assert property (div_done |=> !rate_tick_o [*4])
		else $error("tick soon after divisor write");
	wide_cfg_a: assert property (wr_done(OFS_RATE_CONTROL) |-> ##2
		rate_cfg_o.wide_divider_select == $past(avs_writedata_i[3], 2))
		else $error("wide select not applied");
	mode_cfg_a: assert property (wr_done(OFS_TRANSMIT_CONTROL) |-> ##2
		rate_cfg_o.clocked_mode == $past(avs_writedata_i[4], 2) &&
		rate_cfg_o.high_rate_select == $past(avs_writedata_i[2], 2))
		else $error("mode bits not applied");
	reset_out_a: assert property (disable iff (1'b0) reset_i |=>
		!rate_tick_o && rate_cfg_o == 4'h0) else $error("outputs after reset");
endmodule : baud_rate_divider_properties
`default_nettype wire

// File: dv/baud_rate_divider_test.sv
`timescale 1ns/10ps
`default_nettype none
module baud_rate_divider_test
	import rate_pkg::*;
;
	logic        clk_sys_i = 1'b0, reset_i = 1'b1, rd = 1'b0, wr = 1'b0;
	logic        idle = 1'b1, empty = 1'b1;
	logic [4:0]  addr = 5'h00;
	logic [31:0] wdata = 32'h0000_0000, q;
	logic        wait_o, tick;
	rate_cfg_t   cfg;
	int          fail_count = 0, total_checks = 0, cyc = 0;
	logic [4:0]  ofs [6] = '{OFS_RATE_CONTROL, OFS_TRANSMIT_CONTROL,
		OFS_RECEIVE_CONTROL, OFS_DIVISOR_LOW_BYTE, OFS_DIVISOR_HIGH_BYTE, 5'h14};
	logic [7:0]  rst_v [6] = '{8'h40, TC_EMPTY_READ, REG_RESET, REG_RESET,
		REG_RESET, REG_RESET};
	logic [7:0]  ful_v [6] = '{8'h58, 8'hFF, RECEIVE_CONTROL_WMASK, 8'hFF,
		8'hFF, 8'h00};
	logic [2:0]  mode [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
	int          mul [6] = '{64, 16, 16, 4, 4, 4};
	always #5 clk_sys_i = ~clk_sys_i;
	baud_rate_divider i_baud_rate_divider (.clk_sys_i(clk_sys_i),
		.reset_i(reset_i), .avs_address_i(addr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(q),
		.avs_waitrequest_o(wait_o), .receiver_idle_i(idle),
		.transmit_empty_i(empty), .rate_tick_o(tick), .rate_cfg_o(cfg));
	// ==========================================================
	// Tasks
	task test_done;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : test_done
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		total_checks++;
		if (s !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task bus(input logic w, input logic [4:0] a, input logic [7:0] d,
		output logic [31:0] r);
		@(posedge clk_sys_i);
		addr <= a;
		wr <= w;
		rd <= !w;
		wdata <= {24'h00_0000, d};
		do @(posedge clk_sys_i); while (wait_o !== 1'b0);
		r = q;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus
	// Counts from the divisor write edge to the first tick, then one period
	task tick_chk(input int m, input int n);
		int c;
		c = 0;
		do begin @(negedge clk_sys_i); c++; end while (tick !== 1'b1 && c < 5000);
		chk("first tick", m * (n + 1) + 1, c);
		c = 0;
		do begin @(negedge clk_sys_i); c++; end while (tick !== 1'b1 && c < 5000);
		chk("tick period", m * (n + 1), c);
	endtask : tick_chk
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 30000) begin
			fail_count++;
			test_done();
		end
	end
	// ==========================================================
	// Tests
	logic [31:0] r;
	initial begin
		repeat (6) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			bus(1'b0, ofs[i], 8'h00, r);
			chk("reset value", {24'h00_0000, rst_v[i]}, r);
			bus(1'b1, ofs[i], 8'hFF, r);
			bus(1'b0, ofs[i], 8'h00, r);
			chk("written value", {24'h00_0000, ful_v[i]}, r);
		end
		chk("config", 32'h0000_000F, {28'h000_0000, cfg});
		idle <= 1'b0;
		empty <= 1'b0;
		bus(1'b0, OFS_RATE_CONTROL, 8'h00, r);
		chk("idle flag", 32'h0000_0018, r);
		bus(1'b0, OFS_TRANSMIT_CONTROL, 8'h00, r);
		chk("empty flag", 32'h0000_00FD, r);
		$display("test registers done");
		bus(1'b1, OFS_DIVISOR_HIGH_BYTE, 8'h01, r);
		for (int i = 0; i < 6; i++) begin
			bus(1'b1, OFS_RATE_CONTROL, {4'h0, mode[i][1], 3'h0}, r);
			bus(1'b1, OFS_TRANSMIT_CONTROL,
				{3'h0, mode[i][2], 1'b0, mode[i][0], 2'h0}, r);
			bus(1'b1, OFS_DIVISOR_LOW_BYTE, 8'h02, r);
			tick_chk(mul[i], mode[i][1] ? 258 : 2);
			chk("config", {28'h000_0000, mode[i], 1'b0},
				{28'h000_0000, cfg});
		end
		$display("test rates done");
		@(posedge clk_sys_i);
		reset_i <= 1'b1;
		idle <= 1'b1;
		empty <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		bus(1'b0, OFS_RATE_CONTROL, 8'h00, r);
		chk("reset again", 32'h0000_0040, r);
		chk("config reset", 32'h0000_0000, {28'h000_0000, cfg});
		$display("test reset done");
		test_done();
	end
endmodule : baud_rate_divider_test
bind baud_rate_divider baud_rate_divider_properties i_props (.*);
`default_nettype wire
